/* hw/ssr_pkg.sv */
package ssr_pkg;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RST_HOLD_NS   = 64;
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] RST_HOLD_CNT = RST_HOLD_CYC[7:0];

    // =====================================================================
    // Register offsets (byte addresses)
    // =====================================================================
    localparam logic [7:0] REG_CAUSE_OFS   = 8'h00;
    localparam logic [7:0] REG_IRQ_STAT_OFS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK_OFS = 8'h08;
    localparam logic [7:0] REG_CTRL_OFS    = 8'h0C;
    localparam logic [7:0] REG_PERIPH_OFS  = 8'h10;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int CAUSE_CORE_DROP = 0;
    localparam int CAUSE_IO_DROP   = 1;
    localparam int CAUSE_WDOG      = 2;
    localparam int CAUSE_EXT_PIN   = 3;
    localparam int CAUSE_DEBUG     = 4;
    localparam int CAUSE_W         = 5;

    localparam int IRQ_CORE_WARN   = 0;
    localparam int IRQ_IO_WARN     = 1;
    localparam int IRQ_W           = 2;

    localparam int CTRL_LVD_EN     = 0;
    localparam int CTRL_SRAM_BATT  = 1;

    localparam int PERIPH_W        = 8;

    // Synchroniser lanes for the asynchronous inputs.
    localparam int IN_CORE_DROP    = 0;
    localparam int IN_CORE_WARN    = 1;
    localparam int IN_IO_DROP      = 2;
    localparam int IN_IO_WARN      = 3;
    localparam int IN_EXT_N        = 4;
    localparam int IN_DEBUG        = 5;
    localparam int IN_W            = 6;

    // =====================================================================
    // Values after reset
    // =====================================================================
    localparam logic [IN_W-1:0]     SYNC_RST     = 6'h10;
    localparam logic [CAUSE_W-1:0]  CAUSE_RST    = 5'h00;
    localparam logic [IRQ_W-1:0]    IRQ_RST      = 2'h0;
    localparam logic [1:0]          CTRL_RST     = 2'h0;
    localparam logic [PERIPH_W-1:0] PERIPH_RST   = 8'h00;
    localparam logic [7:0]          CNT_ZERO     = 8'h00;
    localparam logic [7:0]          CNT_ONE      = 8'h01;
    localparam logic [31:0]         WORD_ZERO    = 32'h0000_0000;

    // Reset sequencer phases.
    typedef enum logic [2:0] {
        PH_RUN  = 3'b001,
        PH_CHIP = 3'b010,
        PH_PART = 3'b100
    } ssr_phase_type;

endpackage

/* hw/ssr_supervisor.sv */
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module ssr_supervisor
(
    // Clock and power-up reset.
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Classic Wishbone slave.
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // Reset sources.
    input  wire logic                        core_uv_drop_i,
    input  wire logic                        core_uv_warn_i,
    input  wire logic                        io_supply_uv_drop_i,
    input  wire logic                        io_supply_uv_warn_i,
    input  wire logic                        wdog_expire_i,
    input  wire logic                        ext_reset_in_n_i,
    input  wire logic                        dbg_reset_cmd_i,
    // Reset and power outputs.
    output logic                             chip_wide_reset_o,
    output logic                             partial_reset_o,
    output logic                             clock_control_unit_reset_o,
    output logic      [ssr_pkg::PERIPH_W-1:0] periph_reset_o,
    output logic                             sram_on_battery_o,
    output logic                             rtc_on_battery_o,
    output logic                             irq_o
);
    import ssr_pkg::*;

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [IN_W-1:0]     meta;
        logic [IN_W-1:0]     sync;
        logic [IRQ_W-1:0]    warn_prev;
        ssr_phase_type       phase;
        logic [7:0]          hold_cnt;
        logic [CAUSE_W-1:0]  cause;
        logic [IRQ_W-1:0]    irq_stat;
        logic [IRQ_W-1:0]    irq_mask;
        logic [1:0]          ctrl;
        logic [PERIPH_W-1:0] periph;
        logic                ack;
        logic [31:0]         rdata;
    } ssr_state_type;

    localparam ssr_state_type STATE_RST = '{
        meta:      SYNC_RST,
        sync:      SYNC_RST,
        warn_prev: IRQ_RST,
        phase:     PH_CHIP,
        hold_cnt:  RST_HOLD_CNT,
        cause:     CAUSE_RST,
        irq_stat:  IRQ_RST,
        irq_mask:  IRQ_RST,
        ctrl:      CTRL_RST,
        periph:    PERIPH_RST,
        ack:       1'b0,
        rdata:     WORD_ZERO
    };

    ssr_state_type s_reg;
    ssr_state_type s_next;

    logic [IN_W-1:0]  raw_in;
    logic             gr_evt;
    logic             sr_evt;
    logic             bus_req;
    logic             bus_wr;
    logic [IRQ_W-1:0] warn_now;
    logic [IRQ_W-1:0] warn_rise;

    // =====================================================================
    // Helpers
    // =====================================================================
    // Zero-extends a narrow field into a bus word.
    function automatic logic [31:0] widen(input logic [7:0] v);
        widen = {24'h00_0000, v};
    endfunction

    // Source events from the synchronised inputs and the raw watchdog line.
    assign raw_in    = {dbg_reset_cmd_i, ext_reset_in_n_i, io_supply_uv_warn_i,
                        io_supply_uv_drop_i, core_uv_warn_i, core_uv_drop_i};
    assign gr_evt    = s_reg.sync[IN_CORE_DROP] | s_reg.sync[IN_IO_DROP];
    assign sr_evt    = wdog_expire_i | ~s_reg.sync[IN_EXT_N] | s_reg.sync[IN_DEBUG];
    assign warn_now  = {s_reg.sync[IN_IO_WARN], s_reg.sync[IN_CORE_WARN]};
    assign warn_rise = warn_now & ~s_reg.warn_prev;
    assign bus_req   = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];

    // =====================================================================
    // Next-state logic
    // =====================================================================
    // Computes every field of the next state from the present one.
    always_comb
    begin
        s_next           = s_reg;
        s_next.meta      = raw_in;
        s_next.sync      = s_reg.meta;
        s_next.warn_prev = warn_now;
        s_next.ack       = bus_req;

        // Reset sequencer: chip-wide wins, and each reset is held for a minimum time.
        unique case (s_reg.phase)
            PH_RUN:
            begin
                s_next.hold_cnt = CNT_ZERO;
            end
            PH_CHIP, PH_PART:
            begin
                if (s_reg.hold_cnt == CNT_ONE)
                begin
                    s_next.phase = PH_RUN;
                end
                s_next.hold_cnt = s_reg.hold_cnt - CNT_ONE;
            end
        endcase
        if (gr_evt)
        begin
            s_next.phase    = PH_CHIP;
            s_next.hold_cnt = RST_HOLD_CNT;
        end
        // A partial request in the last cycle of a chip-wide hold still starts a partial reset.
        else if (sr_evt && s_next.phase != PH_CHIP)
        begin
            s_next.phase    = PH_PART;
            s_next.hold_cnt = RST_HOLD_CNT;
        end

        // Reset cause bits set while their source is active and are never cleared here.
        s_next.cause[CAUSE_CORE_DROP] = s_reg.cause[CAUSE_CORE_DROP] | s_reg.sync[IN_CORE_DROP];
        s_next.cause[CAUSE_IO_DROP]   = s_reg.cause[CAUSE_IO_DROP] | s_reg.sync[IN_IO_DROP];
        s_next.cause[CAUSE_WDOG]      = s_reg.cause[CAUSE_WDOG] | wdog_expire_i;
        s_next.cause[CAUSE_EXT_PIN]   = s_reg.cause[CAUSE_EXT_PIN] | ~s_reg.sync[IN_EXT_N];
        s_next.cause[CAUSE_DEBUG]     = s_reg.cause[CAUSE_DEBUG] | s_reg.sync[IN_DEBUG];

        // Register writes.
        if (bus_wr)
        begin
            unique case (wb_adr_i)
                REG_IRQ_STAT_OFS: s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[IRQ_W-1:0];
                REG_IRQ_MASK_OFS: s_next.irq_mask = wb_dat_i[IRQ_W-1:0];
                REG_CTRL_OFS:     s_next.ctrl     = wb_dat_i[1:0];
                REG_PERIPH_OFS:   s_next.periph   = wb_dat_i[PERIPH_W-1:0];
                default:          s_next.ctrl     = s_reg.ctrl;
            endcase
        end

        // Warning edges set the sticky status after the clear, so a set wins.
        s_next.irq_stat = s_next.irq_stat | warn_rise;

        // Register reads.
        if (bus_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                REG_CAUSE_OFS:    s_next.rdata = widen({3'h0, s_reg.cause});
                REG_IRQ_STAT_OFS: s_next.rdata = widen({6'h00, s_reg.irq_stat});
                REG_IRQ_MASK_OFS: s_next.rdata = widen({6'h00, s_reg.irq_mask});
                REG_CTRL_OFS:     s_next.rdata = widen({6'h00, s_reg.ctrl});
                REG_PERIPH_OFS:   s_next.rdata = widen(s_reg.periph);
                default:          s_next.rdata = WORD_ZERO;
            endcase
        end

        // Both resets clear the interrupt and peripheral registers, a chip-wide reset also the control register; the cause register is spared.
        if (s_reg.phase != PH_RUN)
        begin
            s_next.irq_stat = IRQ_RST;
            s_next.irq_mask = IRQ_RST;
            s_next.periph   = PERIPH_RST;
        end
        if (s_reg.phase == PH_CHIP)
        begin
            s_next.ctrl = CTRL_RST;
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    // Power-up reset alone clears the cause register.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= STATE_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // Reset outputs follow the sequencer phase; the peripheral resets also follow the peripheral register.
    assign chip_wide_reset_o          = (s_reg.phase == PH_CHIP);
    assign partial_reset_o            = (s_reg.phase != PH_RUN);
    assign clock_control_unit_reset_o = (s_reg.phase == PH_CHIP);
    assign periph_reset_o             = s_reg.periph | {PERIPH_W{partial_reset_o}};

    // SRAM battery switchover needs a core dropout, detection enabled and the SRAM selection set; the RTC switches on either dropout.
    assign rtc_on_battery_o  = s_reg.sync[IN_CORE_DROP] | s_reg.sync[IN_IO_DROP];
    assign sram_on_battery_o = s_reg.sync[IN_CORE_DROP] & s_reg.ctrl[CTRL_LVD_EN]
                               & s_reg.ctrl[CTRL_SRAM_BATT];

    // Level interrupt from unmasked sticky status.
    assign irq_o    = |(s_reg.irq_stat & s_reg.irq_mask);
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdata;

endmodule

/* verification/ssr_supervisor_chk.sv */
`timescale 1ns/1ps
module ssr_supervisor_chk
(
    // Clock and reset.
    input wire logic                         clk_i,
    input wire logic                         rst_i,
    // Bus handshake.
    input wire logic                         wb_cyc_i,
    input wire logic                         wb_stb_i,
    input wire logic                         wb_ack_o,
    // Reset sources.
    input wire logic                         core_uv_drop_i,
    input wire logic                         io_supply_uv_drop_i,
    input wire logic                         wdog_expire_i,
    input wire logic                         ext_reset_in_n_i,
    input wire logic                         dbg_reset_cmd_i,
    // Reset and power outputs.
    input wire logic                         chip_wide_reset_o,
    input wire logic                         partial_reset_o,
    input wire logic                         clock_control_unit_reset_o,
    input wire logic [ssr_pkg::PERIPH_W-1:0] periph_reset_o,
    input wire logic                         sram_on_battery_o,
    input wire logic                         rtc_on_battery_o
);
    import ssr_pkg::*;
    // ==========
    // Properties
    // ==========
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A reset must hold for a stretch, not glitch.
    sequence s_part_hold; partial_reset_o[*8]; endsequence
    sequence s_chip_hold; chip_wide_reset_o[*8]; endsequence
    sequence s_no_chip; !chip_wide_reset_o[*3]; endsequence

    a_core_drop_chip: assert property ($rose(core_uv_drop_i) |-> ##[1:5] chip_wide_reset_o)
        else $error("core dropout gave no chip-wide reset");
    a_io_drop_chip: assert property ($rose(io_supply_uv_drop_i) |-> ##[1:5] chip_wide_reset_o)
        else $error("io dropout gave no chip-wide reset");
    a_wdog_partial: assert property ($rose(wdog_expire_i) |=> s_part_hold)
        else $error("watchdog gave no partial reset");
    a_wdog_not_chip: assert property ($rose(wdog_expire_i) && !chip_wide_reset_o && !core_uv_drop_i
        && !io_supply_uv_drop_i |=> s_no_chip) else $error("watchdog gave chip-wide reset");
    a_pin_partial: assert property ($fell(ext_reset_in_n_i) |-> ##[1:5] partial_reset_o)
        else $error("reset pin gave no partial reset");
    a_dbg_partial: assert property ($rose(dbg_reset_cmd_i) |-> ##[1:5] partial_reset_o)
        else $error("debug command gave no partial reset");
    a_ccu_follows: assert property (clock_control_unit_reset_o == chip_wide_reset_o)
        else $error("clock control reset differs from chip-wide reset");
    a_periph_reset: assert property (partial_reset_o |-> &periph_reset_o)
        else $error("peripherals not reset during reset");
    a_sram_rtc: assert property (sram_on_battery_o |-> rtc_on_battery_o)
        else $error("sram on battery without clock on battery");
    a_chip_hold: assert property ($fell(rst_i) |-> s_chip_hold)
        else $error("chip-wide reset too short after power-up");
    a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus acknowledge not a one-cycle pulse");
endmodule

bind ssr_supervisor ssr_supervisor_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .core_uv_drop_i, .io_supply_uv_drop_i, .wdog_expire_i, .ext_reset_in_n_i, .dbg_reset_cmd_i,
    .chip_wide_reset_o, .partial_reset_o, .clock_control_unit_reset_o, .periph_reset_o,
    .sram_on_battery_o, .rtc_on_battery_o);

/* verification/ssr_far_model.sv */
`timescale 1ns/1ps
module ssr_far_model
(
    // Clock and one-hot event requests: watchdog, pin, debugger.
    input  wire logic       clk_i,
    input  wire logic [2:0] req_i,
    // Reset source lines.
    output logic            wdog_expire_o,
    output logic            ext_reset_in_n_o,
    output logic            dbg_reset_cmd_o
);
    // ======
    // Events
    // ======
    logic       wd_reg  = 1'b0;
    logic [1:0] pin_reg = 2'h0;
    logic [1:0] dbg_reg = 2'h0;
    // Watchdog is a one-cycle pulse; pin and debugger hold three cycles.
    always_ff @(posedge clk_i)
    begin
        wd_reg  <= req_i[0];
        pin_reg <= req_i[1] ? 2'h3 : ((pin_reg != 2'h0) ? pin_reg - 2'h1 : 2'h0);
        dbg_reg <= req_i[2] ? 2'h3 : ((dbg_reg != 2'h0) ? dbg_reg - 2'h1 : 2'h0);
    end
    assign wdog_expire_o    = wd_reg;
    assign ext_reset_in_n_o = (pin_reg == 2'h0);
    assign dbg_reset_cmd_o  = (dbg_reg != 2'h0);
endmodule

/* verification/system_supervisor_reset_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module system_supervisor_reset_bench;
    import ssr_pkg::*;
    // =======
    // Signals
    // =======
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00, periph_reset_o;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_v, ex;
    logic [2:0]  req = 3'h0;
    logic        core_uv_drop_i = 0, core_uv_warn_i = 0, io_supply_uv_drop_i = 0, io_supply_uv_warn_i = 0;
    logic        wb_ack_o, wdog_expire_i, ext_reset_in_n_i, dbg_reset_cmd_i, chip_wide_reset_o, partial_reset_o;
    logic        clock_control_unit_reset_o, sram_on_battery_o, rtc_on_battery_o, irq_o;
    logic [31:0] exp_q[$];
    int          n_mismatch = 0, comparisons = 0, cyc_n = 0;

    ssr_supervisor dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .core_uv_drop_i, .core_uv_warn_i, .io_supply_uv_drop_i, .io_supply_uv_warn_i,
        .wdog_expire_i, .ext_reset_in_n_i, .dbg_reset_cmd_i, .chip_wide_reset_o, .partial_reset_o,
        .clock_control_unit_reset_o, .periph_reset_o, .sram_on_battery_o, .rtc_on_battery_o, .irq_o);
    ssr_far_model far_u (.clk_i, .req_i(req), .wdog_expire_o(wdog_expire_i),
        .ext_reset_in_n_o(ext_reset_in_n_i), .dbg_reset_cmd_o(dbg_reset_cmd_i));

    // Clock generation.
    initial forever #2 clk_i = ~clk_i;

    // Cuts a hang short.
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // Compares every read answer with the oldest expectation.
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
        begin
            exp_v = exp_q.pop_front();
            `CHK("rdata", exp_v, wb_dat_o)
        end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic bus cycle, held until acknowledge.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic quiet();
        do @(posedge clk_i); while (partial_reset_o !== 1'b0);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        logic [7:0] r;
        void'($urandom(24938));
        tick(4);
        rst_i <= 1'b0;
        quiet();
        rd(REG_CAUSE_OFS, 32'h0);
        rd(8'h14, 32'h0);
        $display("test defaults done");
        r = 8'($urandom);
        wb(1'b1, REG_PERIPH_OFS, {24'h0, r});
        tick(1);
        `CHK("periph", r, periph_reset_o)
        rd(REG_PERIPH_OFS, {24'h0, r});
        wb(1'b1, REG_PERIPH_OFS, 32'h0);
        $display("test periph done");
        wb(1'b1, REG_IRQ_MASK_OFS, 32'h1);
        core_uv_warn_i <= 1'b1;
        io_supply_uv_warn_i <= 1'b1;
        tick(6);
        `CHK("irq", 1'b1, irq_o)
        rd(REG_IRQ_STAT_OFS, 32'h3);
        wb(1'b1, REG_IRQ_STAT_OFS, 32'h1);
        tick(1);
        `CHK("irq", 1'b0, irq_o)
        wb(1'b1, REG_IRQ_MASK_OFS, 32'h2);
        tick(1);
        `CHK("irq", 1'b1, irq_o)
        wb(1'b1, REG_IRQ_STAT_OFS, 32'h2);
        tick(1);
        `CHK("irq", 1'b0, irq_o)
        core_uv_warn_i <= 1'b0;
        io_supply_uv_warn_i <= 1'b0;
        $display("test irq done");
        wb(1'b1, REG_CTRL_OFS, 32'h3);
        ex = 32'h0;
        for (int k = 0; k < 3; k++)
        begin
            req <= 3'(1 << k);
            tick(1);
            req <= 3'h0;
            tick(5);
            `CHK("partial", 1'b1, partial_reset_o)
            `CHK("chip", 1'b0, chip_wide_reset_o)
            `CHK("ccu", 1'b0, clock_control_unit_reset_o)
            quiet();
            ex = ex | (32'h1 << (CAUSE_WDOG + k));
            rd(REG_CAUSE_OFS, ex);
            rd(REG_CTRL_OFS, 32'h3);
        end
        $display("test partial done");
        // Core drop with both control bits, io drop, then core drop twice with a single control bit set each time.
        for (int k = 0; k < 4; k++)
        begin
            if (k >= 2)
                wb(1'b1, REG_CTRL_OFS, (k == 2) ? 32'h2 : 32'h1);
            core_uv_drop_i <= (k != 1);
            io_supply_uv_drop_i <= (k == 1);
            tick(3);
            `CHK("sram", (k == 0), sram_on_battery_o)
            tick(2);
            `CHK("chip", 1'b1, chip_wide_reset_o)
            `CHK("ccu", 1'b1, clock_control_unit_reset_o)
            `CHK("rtc", 1'b1, rtc_on_battery_o)
            core_uv_drop_i <= 1'b0;
            io_supply_uv_drop_i <= 1'b0;
            quiet();
            ex = ex | ((k == 1) ? 32'h2 : 32'h1);
            rd(REG_CAUSE_OFS, ex);
            rd(REG_CTRL_OFS, 32'h0);
        end
        $display("test chip done");
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        quiet();
        rd(REG_CAUSE_OFS, 32'h0);
        tick(2);
        $display("test power-up done");
        report_and_stop();
    end
endmodule
